// file: hw/afe_seq_pkg.sv
/*
 * Shared constants for the front-end power-up sequencer: timing counts,
 * serial frame layout, device register offsets and values, and the
 * host controller's own register map.
 * Assumes a single 40 MHz system clock shared by both ends.
 */
package afe_seq_pkg;

    // Clock and timing
    localparam int SYS_PERIOD_NS  = 25;
    localparam int MCLK_HALF_CYC  = 1;
    localparam int MOD_PER_MCLK   = 4;
    localparam int MOD_CYC        = MOD_PER_MCLK * 2 * MCLK_HALF_CYC;
    localparam int TPOR_MOD       = 2 ** 11;
    localparam int TRST_MOD       = 1;
    localparam int POR_CYC        = TPOR_MOD * MOD_CYC;
    localparam int RST_CYC        = TRST_MOD * MOD_CYC;
    localparam int POLL_NS        = 10000;
    localparam int POLL_CYC       = POLL_NS / SYS_PERIOD_NS;
    localparam int SCLK_HALF_CYC  = 2;

    // Serial frame: {opcode, address, data}, MSB first
    localparam int         FRAME_BITS = 16;
    localparam logic [2:0] OP_WRITE   = 3'h2;
    localparam logic [2:0] OP_NOP     = 3'h0;

    // Device register offsets
    localparam int         DEV_REG_NUM     = 10;
    localparam logic [4:0] ADDR_GC1        = 5'h01;
    localparam logic [4:0] ADDR_GC2        = 5'h02;
    localparam logic [4:0] ADDR_LEAD_OFF_CONTROL       = 5'h03;
    localparam logic [4:0] ADDR_CH4        = 5'h04;
    localparam logic [4:0] ADDR_CH5        = 5'h05;
    localparam logic [4:0] ADDR_BIAS_POS   = 5'h06;
    localparam logic [4:0] ADDR_BIAS_NEG   = 5'h07;
    localparam logic [4:0] ADDR_LEAD_OFF_CONTROL_SENSE = 5'h08;
    localparam logic [4:0] ADDR_GC3        = 5'h09;
    localparam logic [7:0] DEV_REG_RST     = 8'h00;

    // Device register fields
    localparam int GC2_COMP_ON   = 6;
    localparam int GC3_AMP_ON    = 2;
    localparam int GC3_REF_INT   = 3;
    localparam int GC3_MEAS      = 4;
    localparam int LEAD_OFF_CONTROL_DC       = 4;
    localparam int LEAD_OFF_CONTROL_THR_LSB  = 5;

    // Values written by the start-up sequence
    localparam logic [7:0] VAL_GC1       = 8'h02;
    localparam logic [7:0] VAL_LEAD_OFF_CONTROL      = 8'h10;
    localparam logic [7:0] VAL_GC2       = 8'hE0;
    localparam logic [7:0] VAL_LEAD_OFF_SENSE_SELECT = 8'h0F;
    localparam logic [7:0] VAL_BIAS_POS  = 8'h07;
    localparam logic [7:0] VAL_BIAS_NEG  = 8'h07;
    localparam logic [7:0] VAL_GC3_AMP   = 8'h4C;
    localparam logic [7:0] VAL_GC3_MEAS  = 8'h5C;
    localparam logic [7:0] VAL_CH4       = 8'h87;
    localparam logic [7:0] VAL_CH5       = 8'h82;
    localparam logic [3:0] SEQ_BASIC_LEN = 4'h7;
    localparam logic [3:0] SEQ_FULL_LEN  = 4'hA;

    // Host controller registers (byte addresses)
    localparam logic [7:0] HREG_CTRL     = 8'h00;
    localparam logic [7:0] HREG_STATUS   = 8'h04;
    localparam logic [7:0] HREG_IRQ_STAT = 8'h08;
    localparam logic [7:0] HREG_IRQ_CLR  = 8'h0C;
    localparam logic [7:0] HREG_IRQ_EN   = 8'h10;
    localparam logic [7:0] HREG_LEAD_OFF_CONTROL     = 8'h14;
    localparam int         CTRL_GO       = 0;
    localparam int         CTRL_MEAS     = 1;
    localparam int         IRQ_W         = 3;
    localparam int         EV_DONE       = 0;
    localparam int         EV_LEAD_OFF_CONTROL       = 1;
    localparam int         EV_SUPPLY     = 2;

endpackage : afe_seq_pkg

// file: hw/afe_link_if.sv
/*
 * Pins between host controller and front-end device.
 * Both ends run on the same system clock; no clocking block.
 */
`timescale 1ns/100ps
interface afe_link_if;
    logic mclk;
    logic reset_n;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;

    modport host   (output mclk, output reset_n, output cs_n, output sclk,
                    output mosi, input miso);
    modport device (input mclk, input reset_n, input cs_n, input sclk,
                    input mosi, output miso);
endinterface : afe_link_if

// file: hw/afe_frame_shifter.sv
/*
 * Serial frame shifter used by the host: one 16-bit full-duplex frame per
 * start pulse, data launched with sclk low, sampled on sclk rise.
 * Assumes start is only raised while no frame is in flight.
 */
`timescale 1ns/100ps
module afe_frame_shifter
    import afe_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Request side
    input  wire logic        pins_on,
    input  wire logic        start,
    input  wire logic [15:0] tx_word,
    output      logic        done,
    output      logic [15:0] rx_word,
    // Serial pins
    input  wire logic        miso,
    output      logic        sclk,
    output      logic        mosi,
    output      logic        cs_n
);
    typedef struct packed {
        logic        active;
        logic [3:0]  half;
        logic [4:0]  bits;
        logic        sclk;
        logic        mosi;
        logic        cs_n;
        logic [15:0] sh;
        logic [15:0] rx;
        logic        done;
    } shift_s;

    shift_s shift_reg;
    shift_s shift_next;

    always_comb begin
        shift_next      = shift_reg;
        shift_next.done = 1'b0;
        if (!pins_on) begin
            // Every pin low while supplies are not yet trusted
            shift_next = '0;
        end else if (!shift_reg.active) begin
            shift_next.cs_n = 1'b1;
            shift_next.sclk = 1'b0;
            shift_next.mosi = 1'b0;
            if (start) begin
                shift_next.active = 1'b1;
                shift_next.cs_n   = 1'b0;
                shift_next.sh     = tx_word;
                shift_next.mosi   = tx_word[15];
                shift_next.half   = 4'h0;
                shift_next.bits   = 5'h00;
            end
        end else if (shift_reg.half != 4'(SCLK_HALF_CYC - 1)) begin
            shift_next.half = shift_reg.half + 4'h1;
        end else begin
            shift_next.half = 4'h0;
            if (!shift_reg.sclk) begin
                shift_next.sclk = 1'b1;
                shift_next.rx   = {shift_reg.rx[14:0], miso};
            end else begin
                shift_next.sclk = 1'b0;
                if (shift_reg.bits == 5'(FRAME_BITS - 1)) begin
                    shift_next.active = 1'b0;
                    shift_next.cs_n   = 1'b1;
                    shift_next.mosi   = 1'b0;
                    shift_next.done   = 1'b1;
                end else begin
                    shift_next.bits = shift_reg.bits + 5'h01;
                    shift_next.sh   = {shift_reg.sh[14:0], 1'b0};
                    shift_next.mosi = shift_reg.sh[14];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    assign done    = shift_reg.done;
    assign rx_word = shift_reg.rx;
    assign sclk    = shift_reg.sclk;
    assign mosi    = shift_reg.mosi;
    assign cs_n    = shift_reg.cs_n;

endmodule : afe_frame_shifter

// file: hw/afe_device.sv
/*
 * Front-end device end: serial register file, pin reset, and lead-off
 * status returned in every frame.
 * Assumes the host's pins come from logic on the same system clock.
 */
`timescale 1ns/100ps
module afe_device
    import afe_seq_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // Link to host
    afe_link_if.device      link,
    // Analog side
    input  wire logic [7:0] leadoff_flags,
    // Configuration outputs
    output      logic [7:0] gc1_value,
    output      logic [2:0] lead_off_control_threshold,
    output      logic       lead_off_control_dc_mode,
    output      logic       comp_on,
    output      logic [7:0] lead_off_control_sense_sel,
    output      logic [7:0] bias_pos_sel,
    output      logic [7:0] bias_neg_sel,
    output      logic       bias_amp_on,
    output      logic       bias_ref_internal,
    output      logic       bias_measure,
    output      logic [7:0] ch4_settings,
    output      logic [7:0] ch5_settings,
    // State
    output      logic       conv_valid,
    output      logic       in_reset
);
    typedef logic [DEV_REG_NUM-1:0][7:0] reg_file_t;

    typedef struct packed {
        reg_file_t   regs;
        logic        sclk_d;
        logic        cs_d;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0]  bits;
        logic        miso;
        logic        valid;
        logic        in_reset;
    } dev_s;

    dev_s dev_reg;
    dev_s dev_next;

    logic [7:0]  status_byte;
    logic [15:0] frame;

    always_comb begin
        // Lead-off status only from enabled comparators and sensed inputs
        status_byte = dev_reg.regs[ADDR_GC2][GC2_COMP_ON]
                    ? (leadoff_flags & dev_reg.regs[ADDR_LEAD_OFF_CONTROL_SENSE]) : 8'h00;
        frame       = {dev_reg.rx[14:0], link.mosi};

        dev_next        = dev_reg;
        dev_next.sclk_d = link.sclk;
        dev_next.cs_d   = link.cs_n;
        if (!link.reset_n) begin
            for (int i = 0; i < DEV_REG_NUM; i++) begin
                dev_next.regs[i] = DEV_REG_RST;
            end
            dev_next.valid    = 1'b0;
            dev_next.bits     = 5'h00;
            dev_next.miso     = 1'b0;
            dev_next.in_reset = 1'b1;
        end else begin
            dev_next.in_reset = 1'b0;
            if (link.cs_n) begin
                dev_next.bits = 5'h00;
                dev_next.miso = 1'b0;
            end else if (dev_reg.cs_d) begin
                dev_next.tx   = {status_byte, 8'h00};
                dev_next.miso = status_byte[7];
                dev_next.bits = 5'h00;
            end else if (link.sclk && !dev_reg.sclk_d) begin
                dev_next.rx   = frame;
                dev_next.bits = dev_reg.bits + 5'h01;
                if (dev_reg.bits == 5'(FRAME_BITS - 1) && frame[15:13] == OP_WRITE
                    && frame[12:8] < 5'(DEV_REG_NUM)) begin
                    // Stored byte drives the block straight away
                    dev_next.regs[frame[12:8]] = frame[7:0];
                    if (frame[12:8] == ADDR_GC1) begin
                        dev_next.valid = 1'b1;
                    end
                end
            end else if (!link.sclk && dev_reg.sclk_d) begin
                dev_next.tx   = {dev_reg.tx[14:0], 1'b0};
                dev_next.miso = dev_reg.tx[14];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dev_reg <= '0;
        end else begin
            dev_reg <= dev_next;
        end
    end

    assign link.miso         = dev_reg.miso;
    assign gc1_value         = dev_reg.regs[ADDR_GC1];
    assign lead_off_control_threshold    = dev_reg.regs[ADDR_LEAD_OFF_CONTROL][LEAD_OFF_CONTROL_THR_LSB +: 3];
    assign lead_off_control_dc_mode      = dev_reg.regs[ADDR_LEAD_OFF_CONTROL][LEAD_OFF_CONTROL_DC];
    assign comp_on           = dev_reg.regs[ADDR_GC2][GC2_COMP_ON];
    assign lead_off_control_sense_sel    = dev_reg.regs[ADDR_LEAD_OFF_CONTROL_SENSE];
    assign bias_pos_sel      = dev_reg.regs[ADDR_BIAS_POS];
    assign bias_neg_sel      = dev_reg.regs[ADDR_BIAS_NEG];
    assign bias_amp_on       = dev_reg.regs[ADDR_GC3][GC3_AMP_ON];
    assign bias_ref_internal = dev_reg.regs[ADDR_GC3][GC3_REF_INT];
    assign bias_measure      = dev_reg.regs[ADDR_GC3][GC3_MEAS];
    assign ch4_settings      = dev_reg.regs[ADDR_CH4];
    assign ch5_settings      = dev_reg.regs[ADDR_CH5];
    assign conv_valid        = dev_reg.valid;
    assign in_reset          = dev_reg.in_reset;

endmodule : afe_device

// file: hw/afe_host.sv
/*
 * Host controller end: supply watch, master clock, power-on wait, reset
 * pulse, start-up register writes, lead-off status polling, and a small
 * software register port with interrupt.
 * Assumes supply_ok is asynchronous; software port is on sys_clk.
 */
`timescale 1ns/100ps
module afe_host
    import afe_seq_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYC
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Software port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output      logic [31:0] rd_data,
    output      logic        irq,
    // Board
    input  wire logic        supply_ok,
    // Link to device
    afe_link_if.host         link
);
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_POR = 3'b001,
        ST_RST = 3'b011,
        ST_CFG = 3'b010,
        ST_RUN = 3'b110
    } host_state_e;

    typedef struct packed {
        host_state_e      st;
        logic [2:0]       sup_sync;
        logic             sup_ok;
        logic             go;
        logic             meas;
        logic [15:0]      cnt;
        logic [3:0]       mdiv;
        logic [3:0]       step;
        logic             busy;
        logic             start;
        logic             poll;
        logic             mclk;
        logic             reset_n;
        logic [7:0]       lead_off_control_stat;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic             irq;
        logic [31:0]      rd_data;
    } host_s;

    host_s host_reg;
    host_s host_next;

    logic        frame_done;
    logic [15:0] rx_word;
    logic [15:0] tx_word;

    // Start-up write list, in issue order
    function automatic logic [15:0] seq_frame(input logic [3:0] idx);
        logic [4:0] a;
        logic [7:0] d;
        a = ADDR_GC1;
        d = VAL_GC1;
        case (idx)
            4'h1: begin a = ADDR_LEAD_OFF_CONTROL;       d = VAL_LEAD_OFF_CONTROL;      end
            4'h2: begin a = ADDR_GC2;        d = VAL_GC2;       end
            4'h3: begin a = ADDR_LEAD_OFF_CONTROL_SENSE; d = VAL_LEAD_OFF_SENSE_SELECT; end
            4'h4: begin a = ADDR_BIAS_POS;   d = VAL_BIAS_POS;  end
            4'h5: begin a = ADDR_BIAS_NEG;   d = VAL_BIAS_NEG;  end
            4'h6: begin a = ADDR_GC3;        d = VAL_GC3_AMP;   end
            4'h7: begin a = ADDR_GC3;        d = VAL_GC3_MEAS;  end
            4'h8: begin a = ADDR_CH4;        d = VAL_CH4;       end
            4'h9: begin a = ADDR_CH5;        d = VAL_CH5;       end
            default: begin a = ADDR_GC1;     d = VAL_GC1;       end
        endcase
        return {OP_WRITE, a, d};
    endfunction : seq_frame

    assign tx_word = host_reg.poll ? {OP_NOP, 5'h00, 8'h00} : seq_frame(host_reg.step);

    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic [3:0]       last;
        ev   = '0;
        clr  = '0;
        last = (host_reg.meas ? SEQ_FULL_LEN : SEQ_BASIC_LEN) - 4'h1;

        host_next          = host_reg;
        host_next.start    = 1'b0;
        host_next.rd_data  = 32'h0000_0000;
        host_next.sup_sync = {host_reg.sup_sync[1:0], supply_ok};
        if (host_reg.sup_sync[1] == host_reg.sup_sync[2]) begin
            host_next.sup_ok = host_reg.sup_sync[2];
        end

        if (wr_en) begin
            case (addr)
                HREG_CTRL: begin
                    host_next.go   = wr_data[CTRL_GO];
                    host_next.meas = wr_data[CTRL_MEAS];
                end
                HREG_IRQ_CLR: clr = wr_data[IRQ_W-1:0];
                HREG_IRQ_EN:  host_next.irq_en = wr_data[IRQ_W-1:0];
                default: ;
            endcase
        end

        // Master clock runs from the power-on wait onward
        if (host_reg.st == ST_OFF) begin
            host_next.mclk = 1'b0;
            host_next.mdiv = 4'h0;
        end else if (host_reg.mdiv == 4'(MCLK_HALF_CYC - 1)) begin
            host_next.mclk = ~host_reg.mclk;
            host_next.mdiv = 4'h0;
        end else begin
            host_next.mdiv = host_reg.mdiv + 4'h1;
        end

        unique case (host_reg.st)
            ST_OFF: begin
                host_next.reset_n = 1'b0;
                host_next.busy    = 1'b0;
                if (host_reg.sup_ok && host_reg.go) begin
                    host_next.st      = ST_POR;
                    host_next.reset_n = 1'b1;
                    host_next.cnt     = 16'h0000;
                end
            end
            ST_POR: begin
                host_next.cnt = host_reg.cnt + 16'h0001;
                // Full count: first mclk edge lags this state by a cycle
                if (host_reg.cnt == 16'(POR_CYCLES)) begin
                    host_next.st      = ST_RST;
                    host_next.reset_n = 1'b0;
                    host_next.cnt     = 16'h0000;
                end
            end
            ST_RST: begin
                host_next.cnt = host_reg.cnt + 16'h0001;
                if (host_reg.cnt == 16'(RST_CYC - 1)) begin
                    host_next.st      = ST_CFG;
                    host_next.reset_n = 1'b1;
                    host_next.step    = 4'h0;
                    host_next.cnt     = 16'h0000;
                end
            end
            ST_CFG: begin
                // One frame in flight at a time keeps the list in order
                if (!host_reg.busy) begin
                    host_next.start = 1'b1;
                    host_next.busy  = 1'b1;
                    host_next.poll  = 1'b0;
                end else if (frame_done) begin
                    host_next.busy = 1'b0;
                    if (host_reg.step == last) begin
                        host_next.st   = ST_RUN;
                        ev[EV_DONE]    = 1'b1;
                    end else begin
                        host_next.step = host_reg.step + 4'h1;
                    end
                end
            end
            ST_RUN: begin
                host_next.cnt = host_reg.cnt + 16'h0001;
                if (!host_reg.busy && host_reg.cnt >= 16'(POLL_CYC - 1)) begin
                    host_next.start = 1'b1;
                    host_next.busy  = 1'b1;
                    host_next.poll  = 1'b1;
                    host_next.cnt   = 16'h0000;
                end else if (host_reg.busy && frame_done) begin
                    host_next.busy      = 1'b0;
                    host_next.lead_off_control_stat = rx_word[15:8];
                    if (rx_word[15:8] != host_reg.lead_off_control_stat) begin
                        ev[EV_LEAD_OFF_CONTROL] = 1'b1;
                    end
                end
            end
            default: begin
                host_next.st = ST_OFF;
            end
        endcase

        // Losing the supply drops every pin low again
        if (!host_reg.sup_ok && host_reg.st != ST_OFF) begin
            host_next.st      = ST_OFF;
            host_next.reset_n = 1'b0;
            host_next.busy    = 1'b0;
            host_next.start   = 1'b0;
            ev[EV_SUPPLY]     = 1'b1;
        end

        // New event wins over a clear in the same cycle
        host_next.irq_stat = (host_reg.irq_stat & ~clr) | ev;
        host_next.irq      = |(host_next.irq_stat & host_next.irq_en);

        if (rd_en) begin
            case (addr)
                HREG_CTRL:     host_next.rd_data = {30'h0, host_reg.meas, host_reg.go};
                HREG_STATUS:   host_next.rd_data = {20'h0, host_reg.step, 1'b0,
                                                    host_reg.st, 2'h0,
                                                    host_reg.st == ST_RUN,
                                                    host_reg.sup_ok};
                HREG_IRQ_STAT: host_next.rd_data = {29'h0, host_reg.irq_stat};
                HREG_IRQ_EN:   host_next.rd_data = {29'h0, host_reg.irq_en};
                HREG_LEAD_OFF_CONTROL:     host_next.rd_data = {24'h0, host_reg.lead_off_control_stat};
                default:       host_next.rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_reg <= '0;
        end else begin
            host_reg <= host_next;
        end
    end

    afe_frame_shifter i_afe_frame_shifter (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .pins_on (host_reg.st != ST_OFF),
        .start   (host_reg.start),
        .tx_word (tx_word),
        .done    (frame_done),
        .rx_word (rx_word),
        .miso    (link.miso),
        .sclk    (link.sclk),
        .mosi    (link.mosi),
        .cs_n    (link.cs_n)
    );

    assign link.mclk    = host_reg.mclk;
    assign link.reset_n = host_reg.reset_n;
    assign rd_data      = host_reg.rd_data;
    assign irq          = host_reg.irq;

endmodule : afe_host

// file: sim/afe_seq_assertions.sv
/* Link assertions for the power-up sequencer.
   Sees the link pins only; instantiated beside the link in the bench. */
`timescale 1ns/100ps
module afe_seq_assertions #(
    parameter int POR_CYCLES = 64
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Link pins
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi
);
    logic [15:0] hi_cnt;
    logic [4:0]  rise_cnt;
    logic        sclk_reg;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt   <= 16'h0;
            rise_cnt <= 5'h0;
            sclk_reg <= 1'b0;
        end else begin
            hi_cnt   <= reset_n ? hi_cnt + 16'h1 : 16'h0;
            rise_cnt <= (cs_n || !reset_n) ? 5'h0 : rise_cnt + {4'h0, sclk && !sclk_reg};
            sclk_reg <= sclk;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Reset pulse taken while the master clock runs
    sequence s_pulse;
        $fell(reset_n) ##1 $changed(mclk) [*2];
    endsequence
    property p_off_quiet;
        !mclk && !$past(mclk) |-> !$past(reset_n) && !cs_n && !sclk && !mosi;
    endproperty
    property p_clock_first;
        $rose(reset_n) |-> ##[1:2] $changed(mclk);
    endproperty
    property p_mclk_run;
        reset_n && $past(reset_n) |-> $changed(mclk);
    endproperty
    property p_por_wait;
        // hi_cnt also holds the cycle before mclk starts
        s_pulse |-> $past(hi_cnt, 2) > POR_CYCLES;
    endproperty
    property p_rst_width;
        s_pulse |-> !reset_n [*6] ##1 reset_n;
    endproperty
    property p_first_write;
        $rose(reset_n) && $past(mclk) != $past(mclk, 2) |-> ##[1:3] !cs_n;
    endproperty
    property p_frame_bits;
        $rose(cs_n) && rise_cnt != 5'h0 |-> rise_cnt == 5'h10;
    endproperty
    property p_mosi_hold;
        sclk |-> $stable(mosi);
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("link pins not low while clock stopped");
    a_clock_first: assert property (p_clock_first)
        else $error("reset released without running clock");
    a_mclk_run: assert property (p_mclk_run)
        else $error("master clock stalled");
    a_por_wait: assert property (p_por_wait)
        else $error("reset pulse too early");
    a_rst_width: assert property (p_rst_width)
        else $error("reset pulse width wrong");
    a_first_write: assert property (p_first_write)
        else $error("no frame after reset pulse");
    a_frame_bits: assert property (p_frame_bits)
        else $error("frame clock count wrong");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("data moved while serial clock high");
endmodule : afe_seq_assertions

// file: sim/afe_powerup_config_sequencer_bench.sv
/* Bench joining host and device ends over the link.
   Assumes package, link and both ends are compiled first. */
`timescale 1ns/100ps
module afe_powerup_config_sequencer_bench
    import afe_seq_pkg::*;
;
    localparam int POR_SIM = 64;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        supply_ok = 1'b0;
    logic [7:0]  flags = 8'h00;
    logic [31:0] rd_data;
    logic        irq;
    logic [7:0]  gc1, sns, bp, bn, c4, c5;
    logic [2:0]  thr;
    logic        dc, cmp, amp, ri, ms, cv, inr;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    afe_link_if link ();
    afe_host #(.POR_CYCLES(POR_SIM)) i_afe_host (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
        .supply_ok(supply_ok), .link(link));
    afe_device i_afe_device (.sys_clk(sys_clk), .rst_b(rst_b), .link(link), .leadoff_flags(flags),
        .gc1_value(gc1), .lead_off_control_threshold(thr), .lead_off_control_dc_mode(dc), .comp_on(cmp),
        .lead_off_control_sense_sel(sns), .bias_pos_sel(bp), .bias_neg_sel(bn), .bias_amp_on(amp),
        .bias_ref_internal(ri), .bias_measure(ms), .ch4_settings(c4), .ch5_settings(c5),
        .conv_valid(cv), .in_reset(inr));
    afe_seq_assertions #(.POR_CYCLES(POR_SIM)) i_afe_seq_assertions (.sys_clk(sys_clk),
        .rst_b(rst_b), .mclk(link.mclk), .reset_n(link.reset_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .mosi(link.mosi));
    always #12.5 sys_clk = ~sys_clk;
    // Whole run needs about 1800 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(nm, rd_data, exp);
    endtask : rd
    task automatic wait_irq(input int lim);
        for (int n = 0; n < lim && irq !== 1'b1; n++) @(posedge sys_clk);
        #1 chk("irq", {31'h0, irq}, 32'h1);
    endtask : wait_irq
    task automatic t_startup();
        wr(HREG_IRQ_EN, 32'h1);
        wr(HREG_CTRL, 32'h1);
        supply_ok <= 1'b1;
        wait_irq(2000);
        rd(HREG_IRQ_STAT, 32'h1, "irq_stat");
        rd(HREG_STATUS, 32'h663, "status");
        rd(8'h40, 32'h0, "unmapped");
        chk("gc1", {cv, gc1}, 32'h102);
        chk("lead_off_control", {thr, dc, cmp}, 32'h3);
        chk("sense", sns, 32'hF);
        chk("bias", {bp, bn}, 32'h0707);
        chk("gc3", {amp, ri, ms}, 32'h6);
    endtask : t_startup
    task automatic t_leadoff();
        wr(HREG_IRQ_CLR, 32'h7);
        wr(HREG_IRQ_EN, 32'h2);
        flags <= 8'hA5;
        wait_irq(1000);
        rd(HREG_LEAD_OFF_CONTROL, 32'h05, "lead_off_control_stat");
        wr(HREG_IRQ_EN, 32'h0);
        @(posedge sys_clk);
        #1 chk("irq_masked", {31'h0, irq}, 32'h0);
    endtask : t_leadoff
    task automatic t_drop();
        wr(HREG_IRQ_CLR, 32'h7);
        supply_ok <= 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 chk("pins", {link.mclk, link.reset_n, link.cs_n, link.sclk, link.mosi}, 32'h0);
        chk("dev_reset", {inr, cv}, 32'h2);
        rd(HREG_IRQ_STAT, 32'h4, "irq_stat");
        wr(HREG_IRQ_CLR, 32'h7);
        wr(HREG_IRQ_EN, 32'h1);
        wr(HREG_CTRL, 32'h3);
        supply_ok <= 1'b1;
        wait_irq(3000);
        chk("gc3", {amp, ri, ms}, 32'h7);
        chk("ch4", c4, 32'h87);
        chk("ch5", c5, 32'h82);
    endtask : t_drop
    task automatic results();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_startup();
        t_leadoff();
        t_drop();
        results();
    end
endmodule : afe_powerup_config_sequencer_bench
